// ---- fctl_controller.sv ----
// fifo ram address controller: address counters, occupancy flags, arbiter, strobes
// assumes synchronous inputs; pins tri-state via separate output enables
`timescale 1ns/100ps
`include "fctl_regs.svh"

// Contract
// - three 14-bit counters: write, read, occupancy
// - occupancy up on write, down on read
// - fourteen three-state ram address outputs
// - unused high address bits float per depth
// - arrival order; tie write wins unless half
// - burst denies opposite direction until released
// - both bursts active: normal priority
// - burst read forces write ready high
// - burst write forces read ready high
// - strobe width stretched by select inputs
// - active-low three-state write strobe, chip select
// - reset clears counters, sets defined pin levels
// - write ready low on request, back next
// - read ready back at select end if nonempty
// - chip disabled floats ram pins, denies requests
// - output latch enable, high in modes 0-3
// - input latch enable and drive enable
// - full set on last write, cleared on read
// - write ready low while full and no burst read
// - half set at half depth, falls on read
// - empty set on last read, cleared on write
// - read ready low while empty and no burst write
// - modes 0-3 select low, 4-7 pulsed
// - depth select halves depth per code step
module fctl_controller
  import fctl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // configuration
  input wire logic chipEnableN,
  input wire logic [2:0] depthSelect,
  input wire logic [2:0] strobeWidthSelect,
  // requests
  input wire logic writeRequestN,
  input wire logic readRequestN,
  input wire logic burstReadN,
  input wire logic burstWriteN,
  // ram interface
  output logic [13:0] ramAddress,
  output logic [13:0] ramAddressOe,
  output logic ramWriteStrobeN,
  output logic ramSelectOutN,
  output logic ramControlOe,
  // handshake and status
  output logic writeReady,
  output logic readReady,
  output logic empty,
  output logic halfFull,
  output logic full,
  // external latches
  output logic outputLatchEnable,
  output logic inputLatchEnable,
  output logic inputLatchDriveN
);
  import fctl_pkg::*;

  fctl_ctl_type ctl_ff;
  fctl_ctl_type nxt_ctl;
  fctl_strobe_if stb ();

  logic ceOn;
  logic burstRd;
  logic burstWr;
  logic capW;
  logic capR;
  logic doW;
  logic wideMode;
  fctl_addr_type depthMask;
  fctl_addr_type halfMark;

  // ----------------------------------------------------------------
  // strobe width timer
  // ----------------------------------------------------------------
  fctl_strobe_timer u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .tmr(stb.timer)
  );

  assign stb.widthCode = strobeWidthSelect[1:0];
  assign wideMode = strobeWidthSelect[`FCTL_WIDE_BIT];

  // ----------------------------------------------------------------
  // request qualification
  // ----------------------------------------------------------------
  assign depthMask = `FCTL_MAX_MASK >> depthSelect;
  assign halfMark = depthMask >> 1;
  assign ceOn = !chipEnableN;
  assign burstRd = !burstReadN && burstWriteN;
  assign burstWr = !burstWriteN && burstReadN;
  assign capW = ceOn && !writeRequestN && ctl_ff.wrRdy && !ctl_ff.pendW && !ctl_ff.full
    && !burstRd;
  assign capR = ceOn && !readRequestN && ctl_ff.rdRdy && !ctl_ff.pendR && !burstWr;
  // pending write served first unless read came first without burst write, or burst read rules
  assign doW = ctl_ff.pendW && (!ctl_ff.pendR || burstWr
    || (!burstRd && ctl_ff.writeFirst));
  assign stb.start = (ctl_ff.state == FCTL_IDLE) && (ctl_ff.pendW || ctl_ff.pendR);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_ctl = ctl_ff;
    // arrival order
    if (capW && capR) begin
      nxt_ctl.writeFirst = !ctl_ff.half;
    end else if (capW && !ctl_ff.pendR) begin
      nxt_ctl.writeFirst = 1'h1;
    end else if (capR && !ctl_ff.pendW) begin
      nxt_ctl.writeFirst = 1'h0;
    end
    if (capW) begin
      nxt_ctl.pendW = 1'h1;
      nxt_ctl.ile = 1'h0;
    end
    if (capR) begin
      nxt_ctl.pendR = 1'h1;
    end
    nxt_ctl.ole = 1'h1;
    case (ctl_ff.state)
      FCTL_IDLE: begin
        if (ctl_ff.pendW || ctl_ff.pendR) begin
          if (doW) begin
            nxt_ctl.state = FCTL_WR;
            nxt_ctl.ildN = 1'h0;
          end else begin
            nxt_ctl.state = FCTL_RD;
          end
        end
      end
      FCTL_WR: begin
        if (stb.done) begin
          nxt_ctl.state = FCTL_IDLE;
          nxt_ctl.pendW = 1'h0;
          nxt_ctl.ile = 1'h1;
          nxt_ctl.ildN = 1'h1;
          nxt_ctl.wrAddr = (ctl_ff.wrAddr + `FCTL_ONE) & depthMask;
          nxt_ctl.occ = (ctl_ff.occ + `FCTL_ONE) & depthMask;
          nxt_ctl.empty = 1'h0;
          if (ctl_ff.occ == depthMask) begin
            nxt_ctl.full = 1'h1;
          end
          if (ctl_ff.occ == halfMark) begin
            nxt_ctl.half = 1'h1;
          end
        end
      end
      FCTL_RD: begin
        if (stb.done) begin
          nxt_ctl.state = FCTL_IDLE;
          nxt_ctl.pendR = 1'h0;
          nxt_ctl.ole = !wideMode;
          nxt_ctl.rdAddr = (ctl_ff.rdAddr + `FCTL_ONE) & depthMask;
          nxt_ctl.occ = (ctl_ff.occ - `FCTL_ONE) & depthMask;
          nxt_ctl.full = 1'h0;
          if (ctl_ff.occ == `FCTL_ONE && !ctl_ff.full) begin
            nxt_ctl.empty = 1'h1;
          end
          if (ctl_ff.occ == halfMark + `FCTL_ONE && !ctl_ff.full) begin
            nxt_ctl.half = 1'h0;
          end
        end
      end
      default: begin
        nxt_ctl.state = FCTL_IDLE;
      end
    endcase
    // handshake levels
    nxt_ctl.wrRdy = !capW && !nxt_ctl.full;
    nxt_ctl.rdRdy = !capR && !nxt_ctl.empty && !nxt_ctl.pendR;
    nxt_ctl.wrRdyOut = burstRd ? 1'h1 : nxt_ctl.wrRdy;
    nxt_ctl.rdRdyOut = burstWr ? 1'h1 : nxt_ctl.rdRdy;
    // ram pins
    nxt_ctl.weN = !(nxt_ctl.state == FCTL_WR);
    nxt_ctl.csN = wideMode ? (nxt_ctl.state == FCTL_IDLE) : 1'h0;
    nxt_ctl.addrOut = (nxt_ctl.state == FCTL_RD) ? nxt_ctl.rdAddr : nxt_ctl.wrAddr;
    nxt_ctl.ctlOe = ceOn || (nxt_ctl.state != FCTL_IDLE);
    nxt_ctl.addrOe = nxt_ctl.ctlOe ? depthMask : `FCTL_ZERO;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctl_ff <= '0;
      ctl_ff.state <= FCTL_IDLE;
      ctl_ff.empty <= `FCTL_RST_EMPTY;
      ctl_ff.half <= `FCTL_RST_HALF;
      ctl_ff.full <= `FCTL_RST_FULL;
      ctl_ff.wrRdy <= `FCTL_RST_WRRDY;
      ctl_ff.rdRdy <= `FCTL_RST_RDRDY;
      ctl_ff.wrRdyOut <= `FCTL_RST_WRRDY;
      ctl_ff.rdRdyOut <= `FCTL_RST_RDRDY;
      ctl_ff.weN <= `FCTL_RST_STROBE_N;
      ctl_ff.csN <= `FCTL_RST_STROBE_N;
      ctl_ff.ole <= 1'h1;
      ctl_ff.ile <= 1'h1;
      ctl_ff.ildN <= 1'h1;
    end else begin
      ctl_ff <= nxt_ctl;
    end
  end

  assign ramAddress = ctl_ff.addrOut;
  assign ramAddressOe = ctl_ff.addrOe;
  assign ramWriteStrobeN = ctl_ff.weN;
  assign ramSelectOutN = ctl_ff.csN;
  assign ramControlOe = ctl_ff.ctlOe;
  assign writeReady = ctl_ff.wrRdyOut;
  assign readReady = ctl_ff.rdRdyOut;
  assign empty = ctl_ff.empty;
  assign halfFull = ctl_ff.half;
  assign full = ctl_ff.full;
  assign outputLatchEnable = ctl_ff.ole;
  assign inputLatchEnable = ctl_ff.ile;
  assign inputLatchDriveN = ctl_ff.ildN;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [2:0] lowCnt;
  logic [1:0] widthHeld;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lowCnt <= 3'h0;
      widthHeld <= 2'h0;
    end else begin
      lowCnt <= ctl_ff.weN ? 3'h0 : lowCnt + 3'h1;
      if (stb.start) begin
        widthHeld <= strobeWidthSelect[1:0];
      end
    end
  end

  a_full_holds_wrrdy: assert property (@(posedge clk) disable iff (!rst_n)
    ctl_ff.full |-> !ctl_ff.wrRdy) else $error("write ready high while full");

  a_empty_holds_rdrdy: assert property (@(posedge clk) disable iff (!rst_n)
    ctl_ff.empty |-> !ctl_ff.rdRdy) else $error("read ready high while empty");

  a_reset_levels: assert property (@(posedge clk)
    !rst_n |=> (ramWriteStrobeN && ramSelectOutN && empty && !full && !halfFull
    && writeReady && !readReady && ctl_ff.occ == `FCTL_ZERO))
    else $error("wrong levels after reset");

  a_strobe_width: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(ramWriteStrobeN) |-> (lowCnt == {1'h0, widthHeld} + 3'h1))
    else $error("write strobe width wrong");

  a_narrow_select_low: assert property (@(posedge clk) disable iff (!rst_n)
    ($past(rst_n) && !$past(strobeWidthSelect[2])) |-> !ramSelectOutN)
    else $error("select not low in narrow mode");

  a_occ_write_inc: assert property (@(posedge clk) disable iff (!rst_n)
    (ctl_ff.state == FCTL_WR && stb.done) |=>
    ctl_ff.occ == (($past(ctl_ff.occ) + `FCTL_ONE) & $past(depthMask)))
    else $error("occupancy did not count up");

  a_addr_hiz_unused: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 ((ramAddressOe & ~($past(`FCTL_MAX_MASK >> depthSelect))) == `FCTL_ZERO))
    else $error("unused address bit driven");

  a_wrrdy_ack: assert property (@(posedge clk) disable iff (!rst_n)
    (capW && !burstRd) |=> !writeReady ##1 (ctl_ff.wrRdy || ctl_ff.full))
    else $error("write ready handshake wrong");

  a_burst_wr_ready: assert property (@(posedge clk) disable iff (!rst_n)
    burstWr |=> readReady) else $error("read ready not forced in burst write");

  a_burst_rd_ready: assert property (@(posedge clk) disable iff (!rst_n)
    burstRd |=> writeReady) else $error("write ready not forced in burst read");

  a_burst_denies: assert property (@(posedge clk) disable iff (!rst_n)
    (burstRd && !ctl_ff.pendW) |=> !ctl_ff.pendW) else $error("write taken in burst read");

  a_ce_floats: assert property (@(posedge clk) disable iff (!rst_n)
    (chipEnableN && ctl_ff.state == FCTL_IDLE && !ctl_ff.pendW && !ctl_ff.pendR)
    |=> (!ramControlOe && ramAddressOe == `FCTL_ZERO))
    else $error("ram pins driven while disabled");

  // a restart while busy would reload the count and stretch the running strobe
  a_start_when_idle: assert property (@(posedge clk) disable iff (!rst_n)
    stb.start |-> !stb.busy) else $error("strobe timer restarted while busy");

  // ----------------------------------------------------------------
  // covers
  // ----------------------------------------------------------------

  c_write_cycle: cover property (@(posedge clk) disable iff (!rst_n)
    capW ##[1:8] (ctl_ff.state == FCTL_WR));
  c_read_cycle: cover property (@(posedge clk) disable iff (!rst_n)
    ctl_ff.state == FCTL_RD && stb.done);
  c_tie: cover property (@(posedge clk) disable iff (!rst_n) capW && capR);
  c_full: cover property (@(posedge clk) disable iff (!rst_n) $rose(ctl_ff.full));
  c_burst_full: cover property (@(posedge clk) disable iff (!rst_n)
    burstRd && ctl_ff.full);
endmodule

// ---- fctl_regs.svh ----
// constants of the fifo ram address controller: widths, masks, reset values
// assumes inclusion by bare name from the package and the design files
`ifndef FCTL_REGS_SVH
`define FCTL_REGS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define FCTL_AW 14
`define FCTL_SEL_W 3
`define FCTL_TMR_W 2

// ----------------------------------------------------------------
// field positions and values
// ----------------------------------------------------------------
`define FCTL_WIDE_BIT 2
`define FCTL_MAX_MASK 14'h3FFF
`define FCTL_ONE 14'h0001
`define FCTL_ZERO 14'h0000
`define FCTL_TMR_ZERO 2'h0

// ----------------------------------------------------------------
// reset values of flags and pins
// ----------------------------------------------------------------
`define FCTL_RST_EMPTY 1'h1
`define FCTL_RST_HALF 1'h0
`define FCTL_RST_FULL 1'h0
`define FCTL_RST_WRRDY 1'h1
`define FCTL_RST_RDRDY 1'h0
`define FCTL_RST_STROBE_N 1'h1

`endif

// ---- fctl_pkg.sv ----
// types of the fifo ram address controller
// assumes fctl_regs.svh is on the include path
package fctl_pkg;
  `include "fctl_regs.svh"

  typedef enum logic [1:0] {FCTL_IDLE, FCTL_WR, FCTL_RD} fctl_state_type;

  typedef logic [`FCTL_AW-1:0] fctl_addr_type;

  typedef struct packed {
    fctl_state_type state;
    fctl_addr_type wrAddr;
    fctl_addr_type rdAddr;
    fctl_addr_type occ;
    logic full;
    logic half;
    logic empty;
    logic wrRdy;
    logic rdRdy;
    logic pendW;
    logic pendR;
    logic writeFirst;
    fctl_addr_type addrOut;
    fctl_addr_type addrOe;
    logic ctlOe;
    logic weN;
    logic csN;
    logic wrRdyOut;
    logic rdRdyOut;
    logic ole;
    logic ile;
    logic ildN;
  } fctl_ctl_type;

  typedef struct packed {
    logic busy;
    logic [`FCTL_TMR_W-1:0] cnt;
  } fctl_tmr_type;
endpackage

// ---- fctl_strobe_if.sv ----
// carrier between the controller and its strobe width timer
// assumes both ends run on the controller clock
`timescale 1ns/100ps
interface fctl_strobe_if;
  logic start;
  logic [1:0] widthCode;
  logic busy;
  logic done;

  modport timer (input start, input widthCode, output busy, output done);
  modport user (output start, output widthCode, input busy, input done);
endinterface

// ---- fctl_strobe_timer.sv ----
// strobe width timer: holds a ram cycle for widthCode+1 clocks
// assumes start is raised only while busy is low
`timescale 1ns/100ps
`include "fctl_regs.svh"
module fctl_strobe_timer
  import fctl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link to controller
  fctl_strobe_if.timer tmr
);
  import fctl_pkg::*;

  fctl_tmr_type tmr_ff;
  fctl_tmr_type nxt_tmr;

  // ----------------------------------------------------------------
  // count down
  // ----------------------------------------------------------------
  always_comb begin
    nxt_tmr = tmr_ff;
    if (tmr.start) begin
      nxt_tmr.busy = 1'h1;
      nxt_tmr.cnt = tmr.widthCode;
    end else if (tmr_ff.busy) begin
      if (tmr_ff.cnt == `FCTL_TMR_ZERO) begin
        nxt_tmr.busy = 1'h0;
      end else begin
        nxt_tmr.cnt = tmr_ff.cnt - 2'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tmr_ff <= '0;
    end else begin
      tmr_ff <= nxt_tmr;
    end
  end

  assign tmr.busy = tmr_ff.busy;
  assign tmr.done = tmr_ff.busy && (tmr_ff.cnt == `FCTL_TMR_ZERO);
endmodule

// ---- fctl_ram_model.sv ----
// static ram array with the external input and output data latches
// assumes the controller's pins as plain ports; bus data is 8 bits wide
`timescale 1ns/100ps
module fctl_ram_model (
  // clock
  input wire logic clk,
  // ram pins
  input wire logic [13:0] ramAddress,
  input wire logic [13:0] ramAddressOe,
  input wire logic ramWriteStrobeN,
  input wire logic ramSelectOutN,
  input wire logic ramControlOe,
  // latch controls
  input wire logic inputLatchEnable,
  input wire logic inputLatchDriveN,
  input wire logic outputLatchEnable,
  // user data
  input wire logic [7:0] busIn,
  output logic [7:0] busOut
);
  logic [7:0] mem [0:16383];
  logic [7:0] inLatch = 8'h00;
  logic [7:0] outLatch = 8'h00;
  logic [7:0] lastData = 8'h00;
  logic [7:0] ramData;
  logic sel;

  assign sel = ramControlOe && !ramSelectOutN;
  // a deselected ram does not keep its last value on the data lines
  assign ramData = sel ? mem[ramAddress & ramAddressOe] : ~lastData;
  assign busOut = outLatch;

  always @(posedge clk) begin
    if (sel) lastData <= ramData;
    if (inputLatchEnable) inLatch <= busIn;
    if (outputLatchEnable) outLatch <= ramData;
    if (ramControlOe && !ramWriteStrobeN && !inputLatchDriveN) begin
      mem[ramAddress & ramAddressOe] <= inLatch;
    end
  end
endmodule

// ---- test_fifo_ram_address_controller.sv ----
// self-checking bench of the fifo ram address controller with a ram model
// assumes fctl_pkg and the design files are compiled first
`timescale 1ns/100ps
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin bad_count++; \
  $display("Error %s expected %h seen %h", n, e, s); end end
module test_fifo_ram_address_controller;
  import fctl_pkg::*;
  logic clk = 0, rst_n = 0, ceN = 0, wrN = 1, rdN = 1, brN = 1, bwN = 1;
  logic [2:0] depth = 3'h7, mode = 3'h0;
  logic [7:0] busIn = 8'h00, busOut;
  logic [13:0] ramAddress, ramAddressOe;
  logic ramWriteStrobeN, ramSelectOutN, ramControlOe, writeReady, readReady;
  logic empty, halfFull, full, outputLatchEnable, inputLatchEnable, inputLatchDriveN;
  int bad_count = 0, check_count = 0, occ = 0, wa = 0, stb = 0, ole = 0;
  int seed = 32'hE559;
  logic [7:0] q[$];

  fctl_controller dut (.clk(clk), .rst_n(rst_n), .chipEnableN(ceN), .depthSelect(depth),
    .strobeWidthSelect(mode), .writeRequestN(wrN), .readRequestN(rdN), .burstReadN(brN),
    .burstWriteN(bwN), .ramAddress(ramAddress), .ramAddressOe(ramAddressOe),
    .ramWriteStrobeN(ramWriteStrobeN), .ramSelectOutN(ramSelectOutN),
    .ramControlOe(ramControlOe), .writeReady(writeReady), .readReady(readReady),
    .empty(empty), .halfFull(halfFull), .full(full), .outputLatchEnable(outputLatchEnable),
    .inputLatchEnable(inputLatchEnable), .inputLatchDriveN(inputLatchDriveN));
  fctl_ram_model ram (.clk(clk), .ramAddress(ramAddress), .ramAddressOe(ramAddressOe),
    .ramWriteStrobeN(ramWriteStrobeN), .ramSelectOutN(ramSelectOutN),
    .ramControlOe(ramControlOe), .inputLatchEnable(inputLatchEnable),
    .inputLatchDriveN(inputLatchDriveN), .outputLatchEnable(outputLatchEnable),
    .busIn(busIn), .busOut(busOut));

  always #50 clk = ~clk;

  // ----------------------------------------------------------------
  // pulse counters
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (!ramWriteStrobeN) stb++;
    if (!outputLatchEnable) ole++;
    if (!ramWriteStrobeN && !mode[2]) `CHK("select", 1'b0, ramSelectOutN)
  end

  task summarize;
    if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // one request, its ram cycle and the flags after it
  // ----------------------------------------------------------------
  task automatic op(input bit w);
    int k;
    bit ok;
    ok = !ceN && (w ? (occ < 128) : (occ > 0));
    @(posedge clk);
    stb = 0;
    ole = 0;
    busIn <= 8'($random(seed));
    if (w) wrN <= 0; else rdN <= 0;
    k = 0;
    @(posedge clk);
    #1;
    while ((w ? writeReady : readReady) === 1'b1 && k < 4) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (ok && k == 4) begin bad_count++; summarize; end
    @(posedge clk);
    wrN <= 1;
    rdN <= 1;
    if (ok && w) begin q.push_back(busIn); wa++; end
    repeat (8) begin
      @(posedge clk);
      #1 if (!outputLatchEnable && ok && !w && mode[2]) `CHK("rdata", q[0], busOut)
    end
    if (ok) occ += w ? 1 : -1;
    if (ok && !w) void'(q.pop_front());
    `CHK("strobes", (ok && w) ? int'(mode[1:0]) + 1 : 0, stb)
    `CHK("olepulse", (ok && !w && mode[2]) ? 1 : 0, ole)
    `CHK("empty", occ == 0, empty)
    `CHK("half", occ >= 64, halfFull)
    `CHK("full", occ == 128, full)
  endtask

  // both requests on one edge; the first ram cycle shows the winner
  task automatic tie(input bit rdFirst);
    @(posedge clk);
    wrN <= 0;
    rdN <= 0;
    busIn <= 8'($random(seed));
    repeat (2) @(posedge clk);
    wrN <= 1;
    rdN <= 1;
    #1 `CHK("tiewinner", rdFirst, ramWriteStrobeN)
    repeat (14) @(posedge clk);
    q.push_back(busIn);
    void'(q.pop_front());
    wa++;
  endtask

  initial begin
    repeat (11) @(posedge clk);
    #1 `CHK("rstflags", 3'b100, {empty, halfFull, full})
    `CHK("rstready", 2'b10, {writeReady, readReady})
    `CHK("rstpins", 5'b11111, {ramWriteStrobeN, ramSelectOutN, inputLatchEnable,
      inputLatchDriveN, outputLatchEnable})
    @(posedge clk);
    rst_n <= 1;
    repeat (2) @(posedge clk);
    #1 `CHK("addroe", 14'h007F, ramAddressOe)
    for (int m = 0; m < 8; m++) begin
      @(posedge clk);
      mode <= 3'(m);
      op(1);
      op(1);
      op(0);
      op(0);
    end
    op(0);
    @(posedge clk);
    mode <= 3'h4;
    repeat (129) op(1);
    `CHK("wrapaddr", 14'(wa % 128), ramAddress)
    @(posedge clk);
    brN <= 0;
    repeat (3) @(posedge clk);
    #1 `CHK("burstrd", 1'b1, writeReady)
    @(posedge clk);
    brN <= 1;
    repeat (3) @(posedge clk);
    #1 `CHK("fullhold", 1'b0, writeReady)
    repeat (28) op(0);
    tie(1);
    repeat (40) op(0);
    tie(0);
    repeat (150) begin
      @(posedge clk);
      mode <= 3'($random(seed));
      op(1'($random(seed)));
    end
    while (occ > 0) op(0);
    @(posedge clk);
    bwN <= 0;
    repeat (3) @(posedge clk);
    #1 `CHK("burstwr", 1'b1, readReady)
    @(posedge clk);
    brN <= 0;
    repeat (3) @(posedge clk);
    #1 `CHK("burstboth", 1'b0, readReady)
    @(posedge clk);
    brN <= 1;
    bwN <= 1;
    ceN <= 1;
    repeat (3) @(posedge clk);
    #1 `CHK("floatpins", 15'h0000, {ramAddressOe, ramControlOe})
    op(1);
    @(posedge clk);
    ceN <= 0;
    depth <= 3'h4;
    repeat (2) @(posedge clk);
    #1 `CHK("addroe4", 14'h03FF, ramAddressOe)
    summarize;
  end
endmodule
